// >>> logic/qudc_defines.svh
// Register offsets, field positions, reset values and bus codes of the counter.
// Assumes inclusion by bare name from the package and the design file.
`ifndef QUDC_DEFINES_SVH
`define QUDC_DEFINES_SVH
// Register byte offsets
`define QUDC_OFF_CTRL 8'h00
`define QUDC_OFF_FILT 8'h04
`define QUDC_OFF_CNT 8'h08
`define QUDC_OFF_MAX 8'h0C
`define QUDC_OFF_MIN 8'h10
`define QUDC_OFF_STAT 8'h14
`define QUDC_OFF_IEN 8'h18
`define QUDC_OFF_ICLR 8'h1C
`define QUDC_OFF_PINS 8'h20
// Status bit positions
`define QUDC_ST_ABOVE 0
`define QUDC_ST_BELOW 1
`define QUDC_ST_CERR 2
`define QUDC_ST_INDEX 3
`define QUDC_ST_AZERO 4
`define QUDC_NSTAT 5
// Reset values
`define QUDC_RST_FILT 16'h0004
`define QUDC_RST_MAX 32'h7FFFFFFF
`define QUDC_RST_MIN 32'h80000000
// Direction modes
`define QUDC_DIR_CODE 2'h0
`define QUDC_DIR_LEVEL 2'h1
`define QUDC_DIR_EDGES 2'h2
// Bus answers
`define QUDC_RESP_OK 2'h0
`define QUDC_RESP_ERR 2'h2
`endif

// >>> logic/qudc_pkg.sv
// Types shared by the counter design.
// Assumes the defines header sits beside it.
`include "qudc_defines.svh"
package qudc_pkg;
  // Control register layout, bit 31 downward
  typedef struct packed {
    logic [24:0] rsv;     // Reads as zero
    logic dir_inv;        // Invert direction pin level
    logic idx_zero;       // Index edge zeroes the count
    logic auto_zero;      // Boundary hit zeroes the count
    logic [1:0] dir_mode; // Direction source
    logic binary;         // Binary code instead of quadrature
    logic enable;         // Counting enabled
  } qudc_ctrl_t;
  // Count events forwarded to the interval timer
  typedef struct packed {
    logic up;
    logic down;
  } qudc_evt_t;
endpackage : qudc_pkg

// >>> logic/qudc_top.sv
// Quadrature / binary up-down position counter with AXI4-Lite registers.
// Assumes encoder pins synchronous-safe after the internal two-flop stage.
`timescale 1ns/1ps
`default_nettype none
`include "qudc_defines.svh"
module qudc_top #(
  parameter int FILT_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] cnt_pins,
  output qudc_pkg::qudc_evt_t cnt_evt,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Code to position within the four-step cycle
  function automatic logic [1:0] qudc_to_bin(input logic [1:0] c, input logic bin_mode);
    qudc_to_bin = bin_mode ? c : {c[1], c[1] ^ c[0]};
  endfunction : qudc_to_bin
  // Byte-lane merge of a write
  function automatic logic [31:0] qudc_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      qudc_merge[i*8 +: 8] = st[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : qudc_merge

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  qudc_pkg::qudc_ctrl_t ctrl_reg; // Control fields
  logic [FILT_W-1:0] filt_reg; // Debounce time in cycles
  logic [31:0] cnt_reg; // Position count
  logic [31:0] max_reg; // Upper boundary
  logic [31:0] min_reg; // Lower boundary
  logic [`QUDC_NSTAT-1:0] stat_reg; // Sticky events
  logic [`QUDC_NSTAT-1:0] ien_reg; // Interrupt enables
  logic [2:0] sync1_reg; // First sync stage
  logic [2:0] sync2_reg; // Second sync stage
  logic [2:0] db_reg; // Debounced inputs
  logic [2:0] db_prev_reg; // Debounced inputs, one cycle old
  logic [FILT_W-1:0] db_cnt_reg [3]; // Stability counters
  logic irq_reg;
  qudc_pkg::qudc_evt_t evt_reg;
  // Bus answer registers
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------
  // Input synchroniser and debounce
  // ----------------------------------------
  // Two-flop stage; only the second stage feeds the filter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= cnt_pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Each input follows its pin only after filt_reg + 1 stable cycles
  for (genvar g = 0; g < 3; g++) begin : g_db
    wire differs = sync2_reg[g] != db_reg[g];
    wire settled = db_cnt_reg[g] >= filt_reg;
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        db_cnt_reg[g] <= '0;
        db_reg[g] <= 1'b0;
      end else if (differs && settled) begin
        db_reg[g] <= sync2_reg[g];
        db_cnt_reg[g] <= '0;
      end else if (differs) begin
        db_cnt_reg[g] <= db_cnt_reg[g] + 1'b1;
      end else begin
        db_cnt_reg[g] <= '0; // Glitch restarts the filter
      end
    end
  end

  // Edge history of the filtered inputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      db_prev_reg <= 3'h0;
    end else begin
      db_prev_reg <= db_reg;
    end
  end

  // ----------------------------------------
  // Step decode
  // ----------------------------------------
  // Position within the cycle, now and one cycle ago
  wire [1:0] pos_now = qudc_to_bin(db_reg[1:0], ctrl_reg.binary);
  wire [1:0] pos_old = qudc_to_bin(db_prev_reg[1:0], ctrl_reg.binary);
  wire [1:0] delta = pos_now - pos_old;
  // Rising edges of the filtered inputs
  wire rise_a = db_reg[0] & ~db_prev_reg[0];
  wire rise_b = db_reg[1] & ~db_prev_reg[1];
  wire rise_z = db_reg[2] & ~db_prev_reg[2];
  // Direction source decode
  wire mode_code = ctrl_reg.dir_mode == `QUDC_DIR_CODE;
  wire mode_level = ctrl_reg.dir_mode == `QUDC_DIR_LEVEL;
  wire mode_edges = ctrl_reg.dir_mode == `QUDC_DIR_EDGES;
  wire dir_down = db_reg[1] ^ ctrl_reg.dir_inv;
  // Code mode: single step each way; two steps is a code error
  wire code_up = mode_code && delta == 2'h1;
  wire code_dn = mode_code && delta == 2'h3;
  wire code_err = ctrl_reg.enable && mode_code && delta == 2'h2;
  // Level mode: input A clocks, pin B gives direction
  wire lvl_up = mode_level && rise_a && !dir_down;
  wire lvl_dn = mode_level && rise_a && dir_down;
  // Edge mode: A counts up, B counts down, both cancel
  wire edg_up = mode_edges && rise_a && !rise_b;
  wire edg_dn = mode_edges && rise_b && !rise_a;
  // Combined step requests; enable gates every source
  wire step_up = ctrl_reg.enable && (code_up || lvl_up || edg_up);
  wire step_dn = ctrl_reg.enable && (code_dn || lvl_dn || edg_dn);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Taken only with both halves offered and no answer pending
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg && !awready_reg;
  wire rd_go = s_axi_arvalid && !rvalid_reg && !arready_reg;
  // Register selects
  wire wr_ctrl = wr_go && s_axi_awaddr == `QUDC_OFF_CTRL;
  wire wr_filt = wr_go && s_axi_awaddr == `QUDC_OFF_FILT;
  wire wr_cnt = wr_go && s_axi_awaddr == `QUDC_OFF_CNT;
  wire wr_max = wr_go && s_axi_awaddr == `QUDC_OFF_MAX;
  wire wr_min = wr_go && s_axi_awaddr == `QUDC_OFF_MIN;
  wire wr_ien = wr_go && s_axi_awaddr == `QUDC_OFF_IEN;
  wire wr_iclr = wr_go && s_axi_awaddr == `QUDC_OFF_ICLR;
  // Writes to read-only registers are ignored but answered OKAY
  wire wr_ro = wr_go && (s_axi_awaddr == `QUDC_OFF_STAT || s_axi_awaddr == `QUDC_OFF_PINS);
  wire wr_hit = wr_ctrl | wr_filt | wr_cnt | wr_max | wr_min | wr_ien | wr_iclr | wr_ro;
  wire [31:0] wr_cnt_val = qudc_merge(cnt_reg, s_axi_wdata, s_axi_wstrb);

  // ----------------------------------------
  // Count and boundary logic
  // ----------------------------------------
  // One step up or down, wrapping at the ends
  wire [31:0] cnt_step = step_up ? cnt_reg + 32'h1 : cnt_reg - 32'h1;
  wire az_hit = ctrl_reg.auto_zero && (step_up || step_dn)
                && (cnt_step == max_reg || cnt_step == min_reg);
  wire idx_hit = ctrl_reg.enable && ctrl_reg.idx_zero && rise_z;
  // Priority: software load, index, auto-zero, step
  wire [31:0] cnt_next = wr_cnt ? wr_cnt_val
                       : idx_hit ? 32'h0
                       : az_hit ? 32'h0
                       : (step_up || step_dn) ? cnt_step : cnt_reg;
  // Boundaries compared against the value the counter will hold
  wire above = $signed(cnt_next) > $signed(max_reg);
  wire below = $signed(cnt_next) < $signed(min_reg);
  // Bit order follows the status register
  wire [`QUDC_NSTAT-1:0] stat_set = {az_hit, rise_z, code_err, below, above};
  wire [`QUDC_NSTAT-1:0] stat_clr = wr_iclr ? s_axi_wdata[`QUDC_NSTAT-1:0] : '0;
  // Set beats a clear in the same cycle
  wire [`QUDC_NSTAT-1:0] stat_next = (stat_reg & ~stat_clr) | stat_set;

  // Position counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Software-set configuration
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= '0;
      filt_reg <= FILT_W'(`QUDC_RST_FILT);
      max_reg <= `QUDC_RST_MAX;
      min_reg <= `QUDC_RST_MIN;
      ien_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= qudc_merge(ctrl_reg, s_axi_wdata, s_axi_wstrb) & 32'h7F;
      if (wr_filt) filt_reg <= FILT_W'(qudc_merge(32'(filt_reg), s_axi_wdata, s_axi_wstrb));
      if (wr_max) max_reg <= qudc_merge(max_reg, s_axi_wdata, s_axi_wstrb);
      if (wr_min) min_reg <= qudc_merge(min_reg, s_axi_wdata, s_axi_wstrb);
      if (wr_ien) ien_reg <= s_axi_wdata[`QUDC_NSTAT-1:0];
    end
  end

  // Status, interrupt and timer events
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_reg <= '0;
      irq_reg <= 1'b0;
      evt_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & ien_reg);
      evt_reg <= '{up: step_up, down: step_dn};
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  wire rd_known = s_axi_araddr <= `QUDC_OFF_PINS && s_axi_araddr[1:0] == 2'h0;
  // Read select; the clear register and holes read as zero
  wire [31:0] rd_mux = (s_axi_araddr == `QUDC_OFF_CTRL) ? 32'(ctrl_reg)
                     : (s_axi_araddr == `QUDC_OFF_FILT) ? 32'(filt_reg)
                     : (s_axi_araddr == `QUDC_OFF_CNT) ? cnt_reg
                     : (s_axi_araddr == `QUDC_OFF_MAX) ? max_reg
                     : (s_axi_araddr == `QUDC_OFF_MIN) ? min_reg
                     : (s_axi_araddr == `QUDC_OFF_STAT) ? 32'(stat_reg)
                     : (s_axi_araddr == `QUDC_OFF_IEN) ? 32'(ien_reg)
                     : (s_axi_araddr == `QUDC_OFF_PINS) ? 32'(db_reg) : 32'h0;

  // Write channel: both halves taken together, answer next cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `QUDC_RESP_OK;
    end else begin
      awready_reg <= wr_go;
      wready_reg <= wr_go;
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `QUDC_RESP_OK : `QUDC_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel: data ready one cycle after the address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `QUDC_RESP_OK;
      rdata_reg <= 32'h0;
    end else begin
      arready_reg <= rd_go;
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_known ? rd_mux : 32'h0;
        rresp_reg <= rd_known ? `QUDC_RESP_OK : `QUDC_RESP_ERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Every output comes straight from a flip-flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign irq = irq_reg;
  assign cnt_evt = evt_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_count_up: assert property (step_up && !wr_cnt && !idx_hit && !az_hit
    |=> cnt_reg == $past(cnt_reg) + 32'h1) else $error("count did not rise by one");
  chk_code_step: assert property (ctrl_reg.enable && mode_code && !ctrl_reg.binary
    && db_prev_reg[1:0] == 2'h0 && db_reg[1:0] == 2'h1 |-> step_up) else $error("quadrature step missed");
  chk_dir_level: assert property (ctrl_reg.enable && mode_level && rise_a && dir_down
    |-> step_dn && !step_up) else $error("level direction ignored");
  chk_two_edges: assert property (ctrl_reg.enable && mode_edges && rise_b && !rise_a
    |-> step_dn) else $error("down edge missed");
  chk_index_zero: assert property (idx_hit && !wr_cnt |=> cnt_reg == 32'h0
    && stat_reg[`QUDC_ST_INDEX]) else $error("index did not zero count");
  chk_filter_hold: assert property ($changed(db_reg[0]) && !$past(sys_rst)
    |-> $past(sync2_reg[0], 1) == db_reg[0]
    && $past(db_cnt_reg[0]) >= $past(filt_reg)) else $error("debounce passed early");
  chk_event_fwd: assert property (step_up |=> cnt_evt.up && !cnt_evt.down)
    else $error("count event not forwarded");
  chk_auto_zero: assert property (az_hit && !wr_cnt |=> cnt_reg == 32'h0
    && stat_reg[`QUDC_ST_AZERO]) else $error("auto-zero failed");
  chk_irq_above: assert property (above && ien_reg[`QUDC_ST_ABOVE] && !wr_ien
    |=> irq && stat_reg[`QUDC_ST_ABOVE]) else $error("boundary interrupt missing");
  chk_code_err: assert property (code_err && !wr_cnt && !idx_hit |=> stat_reg[`QUDC_ST_CERR]
    && cnt_reg == $past(cnt_reg)) else $error("double change not flagged");
  chk_sync_path: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
    |-> sync2_reg == $past(cnt_pins, 2)) else $error("synchroniser depth wrong");
  // Gating, stickiness and event checks
  chk_edge_cancel: assert property (ctrl_reg.enable && mode_edges && rise_a && rise_b
    |-> !step_up && !step_dn) else $error("simultaneous edges counted");
  chk_count_off: assert property (!ctrl_reg.enable
    |-> !step_up && !step_dn && !code_err && !idx_hit) else $error("disabled counter moved");
  chk_event_down: assert property (step_dn |=> cnt_evt.down && !cnt_evt.up)
    else $error("down event not forwarded");
  chk_stat_sticky: assert property (stat_reg[`QUDC_ST_ABOVE] && !wr_iclr
    |=> stat_reg[`QUDC_ST_ABOVE]) else $error("status bit lost");
  chk_irq_quiet: assert property (!(|(stat_next & ien_reg)) |=> !irq)
    else $error("interrupt without enabled status");

  cov_count_up: cover property (step_up ##1 cnt_evt.up);
  cov_count_down: cover property (step_dn ##1 cnt_evt.down);
  cov_irq: cover property (!irq ##1 irq);
  cov_auto_zero: cover property (az_hit);
  cov_index: cover property (idx_hit);
endmodule : qudc_top
`default_nettype wire

// >>> testbench/qudc_enc_model.sv
// Encoder, drive or thumbwheel model driving the three counter pins.
// Assumes the bench raises step for one cycle with up held steady around it.
`timescale 1ns/1ps
`default_nettype none
module qudc_enc_model (
  input wire logic clk_sys,
  input wire logic step,
  input wire logic up,
  input wire logic [2:0] mode,
  input wire logic idx,
  output logic [2:0] pins
);
  // Position and the two phases; the encoder always drives its lines
  logic [1:0] pos = 2'h0;
  logic a = 1'b0;
  logic b = 1'b0;
  // Modes: 0 Gray, 1 binary, 2 pulse and direction, 3 two edges, 4 jump by two
  always @(posedge clk_sys) begin
    if (mode == 3'h2) begin
      b <= ~up;
    end
    if (step) begin
      case (mode)
        3'h2: a <= ~a;
        3'h3: begin
          if (up) a <= ~a;
          else b <= ~b;
        end
        3'h4: pos <= pos + 2'h2;
        default: pos <= up ? pos + 2'h1 : pos - 2'h1;
      endcase
    end
  end
  // Index line above the two phase lines
  assign pins = {idx, mode == 3'h1 ? pos : (mode < 3'h2 || mode == 3'h4) ? {pos[1], ^pos} : {b, a}};
endmodule : qudc_enc_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the position counter: AXI4-Lite master plus encoder model.
// Assumes the design package, defines header and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "qudc_defines.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdv, exp_cnt;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, step = 0, up = 1, idx = 0;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata;
  logic [2:0] mode = 3'h0, pins;
  qudc_pkg::qudc_evt_t evt;
  int errors = 0, samples_checked = 0, eu = 0, ed = 0;
  logic [31:0] nup = 32'h0, ndn = 32'h0; // Four-state tallies so an unknown event shows up
  always #12.5 clk_sys = ~clk_sys;
  // Tally of count events seen by the interval timer
  always @(posedge clk_sys) begin
    nup += evt.up;
    ndn += evt.down;
  end
  qudc_enc_model u_qudc_enc_model (.clk_sys(clk_sys), .step(step), .up(up), .mode(mode), .idx(idx), .pins(pins));
  qudc_top #(.FILT_W(16)) u_qudc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .cnt_pins(pins), .cnt_evt(evt),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // --------------------------------------------------------------
  // Verdict and bus tasks
  // --------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic tmo;
    errors++;
    $display("ERROR bus wait exp answer got none");
    finish_test();
  endtask : tmo
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!got && n < 40) begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
    end
    bready <= 1'b0;
    rs = bresp;
    if (!got) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!got && n < 40) begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
      got = rvalid;
    end
    rready <= 1'b0;
    rs = rresp;
    rdv = rdata;
    if (!got) tmo();
  endtask : rd
  // --------------------------------------------------------------
  // Stimulus helpers and expectations
  // --------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] c, input logic u);
    return u ? c + 32'h1 : c - 32'h1;
  endfunction : nxt
  task automatic mv(input logic u);
    @(posedge clk_sys);
    up <= u;
    repeat (8) @(posedge clk_sys);
    step <= 1'b1;
    @(posedge clk_sys);
    step <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : mv
  // Random walk; pair modes need two pin toggles for one count
  task automatic walk(input int n, input logic pair);
    logic u;
    for (int i = 0; i < n; i++) begin
      u = 1'($urandom % 2);
      mv(u);
      if (pair) mv(u);
      exp_cnt = nxt(exp_cnt, u);
      eu += u;
      ed += !u;
    end
  endtask : walk
  task automatic setmode(input logic [2:0] m, input logic [31:0] c);
    @(posedge clk_sys);
    mode <= m;
    repeat (10) @(posedge clk_sys);
    wr(`QUDC_OFF_CTRL, c);
    wr(`QUDC_OFF_CNT, 32'h0);
    wr(`QUDC_OFF_ICLR, 32'h1F);
    #1;
    {nup, ndn, eu, ed} = '0;
    exp_cnt = 32'h0;
  endtask : setmode
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys);
    tmo();
  end
  initial begin
    void'($urandom(32'hF5C23E56));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`QUDC_OFF_FILT);
    `CHK("filt reset", 32'h4, rdv)
    rd(`QUDC_OFF_MAX);
    `CHK("max reset", 32'h7FFFFFFF, rdv)
    rd(8'h24);
    `CHK("unmapped resp", `QUDC_RESP_ERR, rs)
    wr(`QUDC_OFF_FILT, 32'h0);
    `CHK("write resp", `QUDC_RESP_OK, rs)
    wr(8'h24, 32'h0);
    `CHK("unmapped write", `QUDC_RESP_ERR, rs)
    $display("test reset done");
    setmode(3'h0, 32'h1);
    walk(24, 1'b0);
    rd(`QUDC_OFF_CNT);
    `CHK("quad count", exp_cnt, rdv)
    `CHK("up events", eu, nup)
    `CHK("down events", ed, ndn)
    mode <= 3'h4;
    mv(1'b1);
    rd(`QUDC_OFF_STAT);
    `CHK("code error", 1'b1, rdv[`QUDC_ST_CERR])
    $display("test quadrature done");
    setmode(3'h1, 32'h3);
    walk(12, 1'b0);
    rd(`QUDC_OFF_CNT);
    `CHK("binary count", exp_cnt, rdv)
    setmode(3'h2, 32'h5);
    walk(8, 1'b1);
    rd(`QUDC_OFF_CNT);
    `CHK("level count", exp_cnt, rdv)
    setmode(3'h3, 32'h9);
    walk(8, 1'b1);
    rd(`QUDC_OFF_CNT);
    `CHK("edge count", exp_cnt, rdv)
    setmode(3'h2, 32'h45);
    walk(8, 1'b1);
    rd(`QUDC_OFF_CNT);
    `CHK("inverted count", 32'h0 - exp_cnt, rdv)
    $display("test modes done");
    setmode(3'h0, 32'h1);
    wr(`QUDC_OFF_MAX, 32'h2);
    wr(`QUDC_OFF_IEN, 32'h1);
    walk(0, 1'b0);
    repeat (3) mv(1'b1);
    rd(`QUDC_OFF_STAT);
    `CHK("above max", 1'b1, rdv[`QUDC_ST_ABOVE])
    `CHK("irq raised", 1'b1, irq)
    wr(`QUDC_OFF_IEN, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    wr(`QUDC_OFF_CNT, 32'h0);
    wr(`QUDC_OFF_ICLR, 32'h1);
    rd(`QUDC_OFF_STAT);
    `CHK("above cleared", 1'b0, rdv[`QUDC_ST_ABOVE])
    wr(`QUDC_OFF_MIN, 32'hFFFFFFFF);
    repeat (2) mv(1'b0);
    rd(`QUDC_OFF_STAT);
    `CHK("below min", 1'b1, rdv[`QUDC_ST_BELOW])
    $display("test bounds done");
    wr(`QUDC_OFF_CNT, 32'h0);
    wr(`QUDC_OFF_MIN, 32'h80000000);
    wr(`QUDC_OFF_CTRL, 32'h11);
    wr(`QUDC_OFF_MAX, 32'h3);
    repeat (3) mv(1'b1);
    rd(`QUDC_OFF_CNT);
    `CHK("auto zero count", 32'h0, rdv)
    rd(`QUDC_OFF_STAT);
    `CHK("auto zero flag", 1'b1, rdv[`QUDC_ST_AZERO])
    wr(`QUDC_OFF_CTRL, 32'h21);
    wr(`QUDC_OFF_CNT, 32'h5);
    idx <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(`QUDC_OFF_PINS);
    `CHK("index pin", 1'b1, rdv[2])
    idx <= 1'b0;
    rd(`QUDC_OFF_CNT);
    `CHK("index zero", 32'h0, rdv)
    rd(`QUDC_OFF_STAT);
    `CHK("index flag", 1'b1, rdv[`QUDC_ST_INDEX])
    wr(`QUDC_OFF_FILT, 32'h8);
    wr(`QUDC_OFF_ICLR, 32'h1F);
    idx <= 1'b1;
    repeat (4) @(posedge clk_sys);
    idx <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rd(`QUDC_OFF_STAT);
    `CHK("glitch filtered", 1'b0, rdv[`QUDC_ST_INDEX])
    $display("test index done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
